// *** design/rtc_evt_pkg.sv ***
/*
   constants, field layouts and carrier types of the alarm, event status
   and interrupt part of the real-time clock.
   assumes the time and calendar counters that feed it run on pclk.
*/
package rtc_evt_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_MODE       = 8'h00;
   localparam logic [7:0] OFS_CAL_ALARM  = 8'h14;
   localparam logic [7:0] OFS_STATUS     = 8'h18;
   localparam logic [7:0] OFS_STATUS_CLR = 8'h1c;
   localparam logic [7:0] OFS_IRQ_SET    = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLR    = 8'h24;
   localparam logic [7:0] OFS_IRQ_STATE  = 8'h28;
   localparam logic [7:0] OFS_VALIDITY   = 8'h2c;

   localparam int          NUM_EVENTS = 5;
   localparam int          NUM_VALID  = 4;

   // mode register fields
   localparam int          MODE_UPD_TIM  = 0;
   localparam int          MODE_UPD_CAL  = 1;
   localparam int          MODE_TSEL_LSB = 8;
   localparam int          MODE_CSEL_LSB = 16;
   localparam logic [31:0] MODE_WMASK    = 32'h0003_0303;
   localparam logic [31:0] MODE_RESET    = 32'h0000_0000;

   // calendar alarm register
   localparam logic [31:0] CAR_WMASK = 32'h9f9f_0000;
   localparam logic [31:0] CAR_RESET = 32'h0000_0000;

   // bcd ranges for the calendar alarm fields
   localparam logic [4:0]  MONTH_MIN   = 5'h01;
   localparam logic [4:0]  MONTH_MAX   = 5'h12;
   localparam logic [4:0]  DATE_MIN    = 5'h01;
   localparam logic [4:0]  DATE_MAX    = 5'h1f;
   localparam logic [3:0]  BCD_DIG_MAX = 4'h9;

   localparam logic [4:0]  MASK_RESET   = 5'h00;
   localparam logic [4:0]  STATUS_RESET = 5'h00;
   localparam logic [3:0]  VALID_RESET  = 4'h0;

   typedef enum logic [1:0] {
      TEV_MINUTE   = 2'b00,
      TEV_HOUR     = 2'b01,
      TEV_MIDNIGHT = 2'b10,
      TEV_NOON     = 2'b11
   } time_event_e;

   typedef enum logic [1:0] {
      CEV_WEEK  = 2'b00,
      CEV_MONTH = 2'b01,
      CEV_YEAR  = 2'b10,
      CEV_RSVD  = 2'b11
   } cal_event_e;

   // one bit per event, bit 0 is update_acknowledge
   typedef struct packed {
      logic calendar_event_flag;
      logic time_event_flag;
      logic second;
      logic alarm;
      logic update_acknowledge;
   } ev_flags_s;

   typedef struct packed {
      logic minute;
      logic hour;
      logic midnight;
      logic noon;
   } time_ticks_s;

   typedef struct packed {
      logic week;
      logic month;
      logic year;
   } cal_ticks_s;

   typedef struct packed {
      logic [4:0] date;
      logic [4:0] month;
   } cal_now_s;

   // calendar alarm register image
   typedef struct packed {
      logic        date_match_enable;
      logic [1:0]  rsv_hi;
      logic [4:0]  date;
      logic        month_match_enable;
      logic [1:0]  rsv_mid;
      logic [4:0]  month;
      logic [15:0] rsv_lo;
   } cal_alarm_s;

endpackage

// *** design/event_flag_bank.sv ***
/*
   sticky event flags, interrupt mask and the single interrupt line.
   assumes set, clear and mask strobes are one-cycle pulses on pclk.
*/
`timescale 1ns/1ps
module event_flag_bank
   import rtc_evt_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire ev_flags_s set_ev,
   input  wire ev_flags_s clr_ev,
   input  wire ev_flags_s mask_set,
   input  wire ev_flags_s mask_clr,
   output ev_flags_s      status_ff,
   output ev_flags_s      mask_ff,
   output logic           irq_ff
);

   ev_flags_s nxt_status;
   ev_flags_s nxt_mask;
   logic      nxt_irq;

   // a set in the clearing cycle wins
   assign nxt_status = set_ev | (status_ff & ~clr_ev);
   assign nxt_mask   = mask_set | (mask_ff & ~mask_clr);
   assign nxt_irq    = |(status_ff & mask_ff);

   // one flag and one mask bit per event
   for (genvar g = 0; g < NUM_EVENTS; g++)
   begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            status_ff[g] <= STATUS_RESET[g];
            mask_ff[g]   <= MASK_RESET[g];
         end
         else
         begin
            status_ff[g] <= nxt_status[g];
            mask_ff[g]   <= nxt_mask[g];
         end
      end
   end

   // level interrupt, one cycle behind the flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ff <= 1'b0;
      else
         irq_ff <= nxt_irq;
   end

endmodule

// *** design/rtc_alarm_event_irq.sv ***
/*
   apb slave for the calendar alarm, event flags, interrupt mask and
   validity flags of the real-time clock.
   assumes the counters, the time alarm and their event pulses run on
   pclk and deliver one-cycle ticks and level match signals.
*/
// The implementer's own choice: the APB slave port.
// Notes on behaviour
// - month alarm field bits 20:16 is compared with the bcd month counter
// - bit 23 enables month matching, zero leaves month out of alarm
// - date alarm field bits 28:24 is compared with the bcd date counter
// - bit 31 enables date matching, zero leaves date out of alarm
// - status bit 0 reads one when time and calendar may be updated
// - status bit 1 sets when at least one comparison is enabled and all enabled ones match, sticky
// - status bit 2 sets on each second tick and stays until cleared
// - status bit 3 latches the selected time event until cleared
// - status bit 4 latches the selected calendar event until cleared
// - writing ones to status clear clears those flags, zeros do nothing
// - writing ones to interrupt enable sets those mask bits
// - writing ones to interrupt disable clears those mask bits
// - mask register reads enable state per source, all off at reset
// - validity bit 0 flags invalid time register contents
// - validity bits 1 to 3 flag calendar, time alarm, calendar alarm
// - update request bits stop counting for programming, clearing resumes
// - time select: minute, hour, midnight, noon for codes 00 to 11
// - calendar select: week, month, year; code 11 gives no event
`timescale 1ns/1ps
module rtc_alarm_event_irq
   import rtc_evt_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        sec_tick,
   input  wire time_ticks_s time_ticks,
   input  wire cal_ticks_s  cal_ticks,
   input  wire cal_now_s    cal_now,
   input  wire logic        time_alarm_hit,
   input  wire logic        time_alarm_any_en,
   input  wire logic        time_invalid,
   input  wire logic        calendar_invalid,
   input  wire logic        time_alarm_invalid,
   output logic             time_update_request,
   output logic             calendar_update_request,
   output time_event_e      time_event_select,
   output cal_event_e       calendar_event_select
);

   // bcd value inside a range with a legal units digit
   function automatic logic bcd_ok(input logic [4:0] v,
                                   input logic [4:0] lo,
                                   input logic [4:0] hi);
      bcd_ok = (v >= lo) && (v <= hi) && (v[3:0] <= BCD_DIG_MAX);
   endfunction

   // expand byte strobes to a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   logic               pready_ff;
   logic               pslverr_ff;
   logic [31:0]        prdata_ff;
   logic [31:0]        mode_ff;
   logic [31:0]        car_ff;
   logic [3:0]         valid_ff;
   logic               alarm_prev_ff;
   logic               stopped_ff;

   logic [31:0]        nxt_mode;
   logic [31:0]        nxt_car;
   logic [3:0]         nxt_valid;
   logic               nxt_stopped;

   wire                access_w;
   wire                done_w;
   wire                wr_w;
   wire [31:0]         lane_w;
   wire [31:0]         data_w;
   wire                hit_mode;
   wire                hit_car;
   wire                hit_stat;
   wire                hit_sclr;
   wire                hit_iset;
   wire                hit_iclr;
   wire                hit_imask;
   wire                hit_valid;
   wire                mapped_w;
   wire [31:0]         rd_w;

   cal_alarm_s         car_s;
   cal_alarm_s         wcar_s;
   ev_flags_s          set_w;
   ev_flags_s          clr_w;
   ev_flags_s          mset_w;
   ev_flags_s          mclr_w;
   ev_flags_s          status_w;
   ev_flags_s          mask_w;
   time_event_e        tsel_w;
   cal_event_e         csel_w;

   wire                month_ok;
   wire                date_ok;
   wire                alarm_now;
   wire                alarm_rise;
   wire                any_req;
   wire                ack_rise;
   wire                tev_hit;
   wire                cev_hit;
   wire                car_bad;

   // apb phases: answer one cycle into the access phase
   assign access_w = psel & penable & ~pready_ff;
   assign done_w   = psel & penable & pready_ff;
   assign wr_w     = done_w & pwrite;
   assign lane_w   = lanes(pstrb);
   assign data_w   = pwdata & lane_w;

   // address decode
   assign hit_mode  = (paddr == OFS_MODE);
   assign hit_car   = (paddr == OFS_CAL_ALARM);
   assign hit_stat  = (paddr == OFS_STATUS);
   assign hit_sclr  = (paddr == OFS_STATUS_CLR);
   assign hit_iset  = (paddr == OFS_IRQ_SET);
   assign hit_iclr  = (paddr == OFS_IRQ_CLR);
   assign hit_imask = (paddr == OFS_IRQ_STATE);
   assign hit_valid = (paddr == OFS_VALIDITY);
   assign mapped_w  = hit_mode | hit_car | hit_stat | hit_sclr |
                      hit_iset | hit_iclr | hit_imask | hit_valid;

   // read mux, write-only registers read as zero
   assign rd_w = hit_mode  ? mode_ff :
                 hit_car   ? car_ff :
                 hit_stat  ? {27'h0, status_w} :
                 hit_imask ? {27'h0, mask_w} :
                 hit_valid ? {28'h0, valid_ff} :
                 32'h0;

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end
      else
      begin
         pready_ff  <= access_w;
         pslverr_ff <= access_w & ~mapped_w;
         prdata_ff  <= (access_w & ~pwrite) ? rd_w : 32'h0;
      end
   end

   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata  = prdata_ff;

   // writable registers merge by byte lane and writable mask
   assign nxt_mode = (wr_w & hit_mode) ?
                     (mode_ff & ~(lane_w & MODE_WMASK)) |
                     (data_w & MODE_WMASK) : mode_ff;
   assign nxt_car  = (wr_w & hit_car) ?
                     (car_ff & ~(lane_w & CAR_WMASK)) |
                     (data_w & CAR_WMASK) : car_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_ff <= MODE_RESET;
         car_ff  <= CAR_RESET;
      end
      else
      begin
         mode_ff <= nxt_mode;
         car_ff  <= nxt_car;
      end
   end

   // mode fields drive the counters outside
   assign time_update_request     = mode_ff[MODE_UPD_TIM];
   assign calendar_update_request = mode_ff[MODE_UPD_CAL];
   assign tsel_w = time_event_e'(mode_ff[MODE_TSEL_LSB +: 2]);
   assign csel_w = cal_event_e'(mode_ff[MODE_CSEL_LSB +: 2]);
   assign time_event_select     = tsel_w;
   assign calendar_event_select = csel_w;

   // calendar alarm compare
   assign car_s     = car_ff;
   assign month_ok  = ~car_s.month_match_enable |
                      (cal_now.month == car_s.month);
   assign date_ok   = ~car_s.date_match_enable |
                      (cal_now.date == car_s.date);
   assign alarm_now = time_alarm_hit & month_ok & date_ok &
                      (time_alarm_any_en |
                       car_s.month_match_enable |
                       car_s.date_match_enable);
   assign alarm_rise = alarm_now & ~alarm_prev_ff;

   // counting halts at the next second tick after a request
   assign any_req     = time_update_request | calendar_update_request;
   assign ack_rise    = any_req & sec_tick & ~stopped_ff;
   assign nxt_stopped = any_req & (stopped_ff | sec_tick);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alarm_prev_ff <= 1'b0;
         stopped_ff    <= 1'b0;
      end
      else
      begin
         alarm_prev_ff <= alarm_now;
         stopped_ff    <= nxt_stopped;
      end
   end

   // selected time and calendar events
   assign tev_hit = ((tsel_w == TEV_MINUTE)   & time_ticks.minute) |
                    ((tsel_w == TEV_HOUR)     & time_ticks.hour) |
                    ((tsel_w == TEV_MIDNIGHT) & time_ticks.midnight) |
                    ((tsel_w == TEV_NOON)     & time_ticks.noon);
   assign cev_hit = ((csel_w == CEV_WEEK)  & cal_ticks.week) |
                    ((csel_w == CEV_MONTH) & cal_ticks.month) |
                    ((csel_w == CEV_YEAR)  & cal_ticks.year);

   // event strobes into the flag bank
   assign set_w.update_acknowledge  = ack_rise;
   assign set_w.alarm               = alarm_rise;
   assign set_w.second              = sec_tick;
   assign set_w.time_event_flag     = tev_hit;
   assign set_w.calendar_event_flag = cev_hit;
   assign clr_w  = (wr_w & hit_sclr) ? data_w[4:0] : '0;
   assign mset_w = (wr_w & hit_iset) ? data_w[4:0] : '0;
   assign mclr_w = (wr_w & hit_iclr) ? data_w[4:0] : '0;

   event_flag_bank u_flags (
      .pclk      (pclk),
      .presetn   (presetn),
      .set_ev    (set_w),
      .clr_ev    (clr_w),
      .mask_set  (mset_w),
      .mask_clr  (mclr_w),
      .status_ff (status_w),
      .mask_ff   (mask_w),
      .irq_ff    (irq)
   );

   // calendar alarm content checked at each write, enabled fields only
   assign wcar_s  = nxt_car;
   assign car_bad = (wcar_s.month_match_enable &
                     ~bcd_ok(wcar_s.month, MONTH_MIN, MONTH_MAX)) |
                    (wcar_s.date_match_enable &
                     ~bcd_ok(wcar_s.date, DATE_MIN, DATE_MAX));
   assign nxt_valid = {(wr_w & hit_car) ? car_bad : valid_ff[3],
                       time_alarm_invalid,
                       calendar_invalid,
                       time_invalid};

   // validity flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         valid_ff <= VALID_RESET;
      else
         valid_ff <= nxt_valid;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_month_cmp: assert property (
      $rose(status_w.alarm) |-> !$past(car_s.month_match_enable) ||
      $past(cal_now.month) == $past(car_s.month))
      else $error("alarm set without month match");

   chk_date_cmp: assert property (
      $rose(status_w.alarm) |-> !$past(car_s.date_match_enable) ||
      $past(cal_now.date) == $past(car_s.date))
      else $error("alarm set without date match");

   chk_alarm_set: assert property (
      alarm_now && !alarm_prev_ff |=> status_w.alarm)
      else $error("alarm match not latched");

   chk_second_flag: assert property (
      sec_tick |=> status_w.second)
      else $error("second tick not latched");

   chk_time_event: assert property (
      (tsel_w == TEV_NOON) && time_ticks.noon
      |=> status_w.time_event_flag)
      else $error("noon event not latched");

   chk_cal_reserved: assert property (
      (csel_w == CEV_RSVD) && !status_w.calendar_event_flag
      |=> !status_w.calendar_event_flag)
      else $error("reserved calendar code raised a flag");

   chk_clear_flag: assert property (
      clr_w.second && !sec_tick |=> !status_w.second)
      else $error("second flag not cleared");

   chk_mask_set: assert property (
      wr_w && hit_iset |=> (mask_w & $past(data_w[4:0]))
      == $past(data_w[4:0]))
      else $error("enable write did not set mask");

   chk_mask_clr: assert property (
      wr_w && hit_iclr |=> (mask_w & $past(data_w[4:0])) == '0)
      else $error("disable write did not clear mask");

   chk_irq_level: assert property (
      |(status_w & mask_w) |=> irq)
      else $error("irq missing for unmasked flag");

   chk_ack_flag: assert property (
      any_req && sec_tick && !stopped_ff |=> status_w.update_acknowledge)
      else $error("update acknowledge not raised");

   // alarm contents graded at the write edge that lands them
   chk_car_valid: assert property (
      wr_w && hit_car |=> valid_ff[3] == $past(car_bad))
      else $error("calendar alarm validity not updated");

   // no request without an unmasked flag behind it
   chk_irq_quiet: assert property (
      !(|(status_w & mask_w)) |=> !irq)
      else $error("irq without unmasked flag");

   cov_alarm: cover property ($rose(status_w.alarm) ##1 irq);
   cov_clear: cover property (clr_w.alarm ##1 !status_w.alarm);
   cov_err: cover property (pslverr);
   cov_ack: cover property ($rose(status_w.update_acknowledge));

endmodule

// *** verif/tb_top.sv ***
/*
   self-checking bench for the rtc alarm, event flag and interrupt block.
   assumes the design package and modules are compiled first; one pclk.
*/
`timescale 1ns/1ps
module tb_top
   import rtc_evt_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        sec_tick;
   time_ticks_s time_ticks;
   cal_ticks_s  cal_ticks;
   cal_now_s    cal_now;
   logic        time_alarm_hit;
   logic        time_alarm_any_en;
   logic        time_invalid;
   logic        calendar_invalid;
   logic        time_alarm_invalid;
   logic        time_update_request;
   logic        calendar_update_request;
   time_event_e time_event_select;
   cal_event_e  calendar_event_select;
   int          n_errors;
   int          compares;
   int          seed;
   int          i;
   logic [31:0] r;
   logic [31:0] c;
   logic [31:0] car_m;
   logic [4:0]  mask_m;
   logic [31:0] q_v;
   logic        e_v;

   rtc_alarm_event_irq u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .sec_tick(sec_tick), .time_ticks(time_ticks), .cal_ticks(cal_ticks),
      .cal_now(cal_now), .time_alarm_hit(time_alarm_hit),
      .time_alarm_any_en(time_alarm_any_en), .time_invalid(time_invalid),
      .calendar_invalid(calendar_invalid),
      .time_alarm_invalid(time_alarm_invalid),
      .time_update_request(time_update_request),
      .calendar_update_request(calendar_update_request),
      .time_event_select(time_event_select),
      .calendar_event_select(calendar_event_select));

   // 50 mhz clock
   always #10 pclk = ~pclk;

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         n_errors++;
         $display("Error at %0t: no bus answer", $time);
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, 4'hf, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, 4'hf, q, e);
      check(q & m, exp, what);
      check({31'h0, e}, 32'h0, "slave error");
   endtask

   // one-cycle event pulses from the counters
   task automatic pulse(input logic s, input logic [3:0] t,
                        input logic [2:0] k);
      @(posedge pclk);
      sec_tick   <= s;
      time_ticks <= t;
      cal_ticks  <= k;
      @(posedge pclk);
      sec_tick   <= 1'b0;
      time_ticks <= 4'h0;
      cal_ticks  <= 3'h0;
   endtask

   task automatic irq_is(input logic exp);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, {31'h0, exp}, "irq level");
   endtask

   function automatic logic bcd_ok(input logic [4:0] v, input logic [4:0] hi);
      return (v >= 5'h01) && (v <= hi) && (v[3:0] <= BCD_DIG_MAX);
   endfunction

   function automatic logic car_bad(input logic [31:0] k);
      return (k[23] && !bcd_ok(k[20:16], MONTH_MAX)) ||
             (k[31] && !bcd_ok(k[28:24], DATE_MAX));
   endfunction

   // alarm needs one enabled field, time or calendar, and every one matching
   function automatic logic alarm_exp(input logic [31:0] k, input cal_now_s n,
                                      input logic t);
      return (t || k[23] || k[31]) &&
             (!k[23] || k[20:16] == n.month) && (!k[31] || k[28:24] == n.date);
   endfunction

   // main sequence
   initial
   begin
      seed = 32'h96dea494;
      n_errors = 0;
      compares = 0;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      sec_tick = 1'b0;
      time_ticks = 4'h0;
      cal_ticks = 3'h0;
      cal_now = 10'h0;
      time_alarm_hit = 1'b0;
      time_alarm_any_en = 1'b0;
      time_invalid = 1'b0;
      calendar_invalid = 1'b0;
      time_alarm_invalid = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CAL_ALARM, '1, 32'h0, "alarm reset");
      rd(OFS_STATUS, '1, 32'h0, "status reset");
      rd(OFS_IRQ_STATE, '1, 32'h0, "mask reset");
      rd(OFS_VALIDITY, '1, 32'h0, "validity reset");
      rd(OFS_STATUS_CLR, '1, 32'h0, "clear reads");
      wr(OFS_STATUS, 32'hffffffff);
      rd(OFS_STATUS, '1, 32'h0, "status read only");
      wr(OFS_IRQ_STATE, 32'hffffffff);
      rd(OFS_IRQ_STATE, '1, 32'h0, "mask read only");
      apb(1'b0, 8'h30, 32'h0, 4'hf, q_v, e_v);
      check({31'h0, e_v}, 32'h1, "unmapped");
      apb(1'b0, 8'h15, 32'h0, 4'hf, q_v, e_v);
      check({31'h0, e_v}, 32'h1, "misaligned");
      $display("test reset and map done");
      // alarm register fields and validity of alarm contents
      for (i = 0; i < 10; i++)
      begin
         r = (i == 0) ? 32'h89930000 : (i == 1) ? 32'h9a8a0000 : $random(seed);
         wr(OFS_CAL_ALARM, r);
         car_m = r & CAR_WMASK;
         rd(OFS_CAL_ALARM, '1, car_m, "alarm reg");
         rd(OFS_VALIDITY, 32'h8, {28'h0, car_bad(car_m), 3'h0}, "nv");
      end
      apb(1'b1, OFS_CAL_ALARM, 32'hffffffff, 4'h8, q_v, e_v);
      car_m = (car_m | 32'hff000000) & CAR_WMASK;
      rd(OFS_CAL_ALARM, '1, car_m, "byte lane");
      $display("test alarm register done");
      // alarm match with random enables and fields
      time_alarm_any_en <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         r = $random(seed);
         cal_now <= r[9:0];
         time_alarm_any_en <= r[12];
         c = {r[31], 2'b00, r[10] ? r[9:5] : r[20:16], r[30], 2'b00,
              r[11] ? r[4:0] : r[25:21], 16'h0};
         car_m = c;
         wr(OFS_STATUS_CLR, 32'h2);
         wr(OFS_CAL_ALARM, c);
         @(posedge pclk);
         time_alarm_hit <= 1'b1;
         repeat (2) @(posedge pclk);
         time_alarm_hit <= 1'b0;
         rd(OFS_STATUS, 32'h2, {30'h0, alarm_exp(c, r[9:0], r[12]), 1'b0}, "alarm");
      end
      $display("test alarm match done");
      // every time and calendar event code
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_MODE, {14'h0, i[1:0], 6'h0, i[1:0], 8'h0});
         rd(OFS_MODE, '1, {14'h0, i[1:0], 6'h0, i[1:0], 8'h0}, "mode");
         @(posedge pclk);
         check({30'h0, time_event_select}, {30'h0, i[1:0]}, "tsel");
         check({30'h0, calendar_event_select}, {30'h0, i[1:0]}, "csel");
         wr(OFS_STATUS_CLR, 32'h18);
         pulse(1'b0, ~(4'h8 >> i), ~(3'h4 >> i));
         rd(OFS_STATUS, 32'h18, 32'h0, "other events");
         pulse(1'b0, 4'h8 >> i, 3'h4 >> i);
         rd(OFS_STATUS, 32'h18, (i < 3) ? 32'h18 : 32'h8, "event");
      end
      $display("test event select done");
      // second flag, mask, interrupt and clears
      wr(OFS_STATUS_CLR, 32'h1f);
      pulse(1'b1, 4'h0, 3'h0);
      rd(OFS_STATUS, '1, 32'h4, "second");
      irq_is(1'b0);
      wr(OFS_IRQ_SET, 32'h4);
      rd(OFS_IRQ_STATE, '1, 32'h4, "mask set");
      irq_is(1'b1);
      wr(OFS_IRQ_CLR, 32'h1b);
      rd(OFS_IRQ_STATE, '1, 32'h4, "mask kept");
      wr(OFS_STATUS_CLR, 32'h1b);
      rd(OFS_STATUS, '1, 32'h4, "status kept");
      wr(OFS_STATUS_CLR, 32'h4);
      rd(OFS_STATUS, '1, 32'h0, "status cleared");
      irq_is(1'b0);
      pulse(1'b1, 4'h0, 3'h0);
      irq_is(1'b1);
      wr(OFS_IRQ_CLR, 32'h4);
      irq_is(1'b0);
      mask_m = 5'h0;
      for (i = 0; i < 10; i++)
      begin
         r = $random(seed);
         wr(r[31] ? OFS_IRQ_CLR : OFS_IRQ_SET, r);
         mask_m = r[31] ? (mask_m & ~r[4:0]) : (mask_m | r[4:0]);
         rd(OFS_IRQ_STATE, '1, {27'h0, mask_m}, "mask");
      end
      $display("test interrupt done");
      // update requests and their acknowledge
      wr(OFS_STATUS_CLR, 32'h1f);
      wr(OFS_MODE, 32'h1);
      @(posedge pclk);
      check({31'h0, time_update_request}, 32'h1, "time req");
      pulse(1'b1, 4'h0, 3'h0);
      rd(OFS_STATUS, '1, 32'h5, "ack time");
      wr(OFS_MODE, 32'h0);
      wr(OFS_STATUS_CLR, 32'h1f);
      pulse(1'b1, 4'h0, 3'h0);
      rd(OFS_STATUS, '1, 32'h4, "no ack");
      wr(OFS_MODE, 32'h2);
      @(posedge pclk);
      check({31'h0, calendar_update_request}, 32'h1, "cal req");
      pulse(1'b1, 4'h0, 3'h0);
      rd(OFS_STATUS, '1, 32'h5, "ack cal");
      $display("test update done");
      // validity inputs
      for (i = 0; i < 6; i++)
      begin
         r = $random(seed);
         @(posedge pclk);
         time_invalid <= r[0];
         calendar_invalid <= r[1];
         time_alarm_invalid <= r[2];
         rd(OFS_VALIDITY, '1, {28'h0, car_bad(car_m), r[2:0]}, "nv");
      end
      $display("test validity done");
      // reset in mid run
      wr(OFS_IRQ_SET, 32'h1f);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_IRQ_STATE, '1, 32'h0, "mask after reset");
      rd(OFS_CAL_ALARM, '1, 32'h0, "alarm after reset");
      $display("test second reset done");
      print_verdict();
   end
endmodule
